//--- verilog/epr_pkg.sv
// Package for the enable-pin reset control block: offsets, fields, timing, types
package epr_pkg;
    // Register addresses (register-file space, 8-bit index)
    localparam logic [7:0] EPR_ADDR_RESET_COUNT = 8'h06;
    localparam logic [7:0] EPR_ADDR_IRQ_STATUS = 8'h3F;
    localparam logic [7:0] EPR_ADDR_PLL_MODE = 8'h40;
    localparam logic [7:0] EPR_ADDR_PLL_REF = 8'h41;
    localparam logic [7:0] EPR_ADDR_PLL_CTRL = 8'h42;
    localparam logic [7:0] EPR_ADDR_IRQ_MASK = 8'h43;
    // Field positions inside the irq status register
    localparam int EPR_BIT_IRQ_FLAG = 0;
    localparam int EPR_BIT_PIN_LEVEL = 1;
    localparam int EPR_BIT_RESET_DONE = 2;
    // Reset values
    localparam logic [3:0] EPR_RESET_COUNT_INIT = 4'h1;
    localparam logic [3:0] EPR_PLL_MODE_INIT = 4'h0;
    localparam logic [3:0] EPR_PLL_REF_INIT = 4'h0;
    localparam logic [3:0] EPR_MASK_INIT = 4'h0;
    // Filter timing
    localparam int EPR_CLK_MHZ = 125;
    localparam int EPR_FILTER_US = 167;
    localparam int EPR_FILTER_CYCLES = EPR_FILTER_US * EPR_CLK_MHZ;
    localparam int EPR_FILT_W = 15;

    typedef enum logic [1:0] {
        EPR_IDLE = 2'b00,
        EPR_COUNT = 2'b01,
        EPR_FIRE = 2'b10
    } epr_state_t;

    // Register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [3:0] wdata;
        logic wr;
        logic rd;
    } epr_bus_t;

    // Pin-side outputs
    typedef struct packed {
        logic pllEnable;
        logic oscPullDown;
        logic errOutEnable;
        logic xtalInPullDown;
        logic xtalOutHigh;
    } epr_pins_t;
endpackage : epr_pkg

//--- verilog/epr_enable_pin_reset.sv
// Enable-pin filter, PLL gating, falling-edge interrupt and timed enable-pin reset
`timescale 1ns/1ps
`default_nettype none
// How it works
// [RQ1] PLL runs only while enable pin high
// [RQ2] PLL off: osc pins pulled low, errors float
// [RQ3] Software may disable PLL anytime
// [RQ4] Disabled PLL stays off until both rewritten
// [RQ5] Filtered falling edge raises interrupt
// [RQ6] Filtered rising edge starts reset sequence
// [RQ7] Ignore levels shorter than 167 us
// [RQ8] Filtered level readable at 3FH
// [RQ9] Count carry pulse edges, reset at match
// [RQ10] Count field n means n counts
// [RQ11] Reset count register read/write at 06H
// [RQ12] Count loads 1 on power-on, clock stop
// [RQ13] Enable reset restarts core at 0000H
// [RQ14] Other reset sources also reset device
// [RQ15] Clock stop: crystal in low, out high
// [RQ16] Interrupt flag readable and writable
// [RQ17] After clock stop, reset one carry edge
// [RQ18] Stable-time counter filter feeds edges
module epr_enable_pin_reset (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic enablePin,
    input wire logic carryPulse,
    input wire logic clockStop,
    input wire logic watchdogStackReset,
    input wire logic resetPin,
    input wire epr_pkg::epr_bus_t bus,
    output logic [3:0] rdata,
    output epr_pkg::epr_pins_t pins,
    output logic irq,
    output logic coreReset,
    output logic enableReset
);
    import epr_pkg::*;

    typedef struct packed {
        logic [2:0] pinSync;
        logic filtLevel;
        logic [EPR_FILT_W-1:0] filtCnt;
        logic carryLast;
        epr_state_t state;
        logic [3:0] carryCnt;
        logic [3:0] resetCount;
        logic [3:0] pllMode;
        logic [3:0] pllRef;
        logic swPllOff;
        logic pllLatchedOff;
        logic modeWritten;
        logic refWritten;
        logic irqFlag;
        logic resetDone;
        logic [3:0] irqMask;
        logic [3:0] rdata;
        epr_pins_t pins;
        logic irq;
        logic coreReset;
        logic enableReset;
    } epr_regs_t;

    epr_regs_t r;
    epr_regs_t next_r;

    // Register decode shared by write and read paths
    function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
        hit = (a == target);
    endfunction : hit

    always_comb begin
        logic rise;
        logic fall;
        logic carryEdge;
        logic stable;
        logic pllRun;
        next_r = r;
        rise = 1'b0;
        fall = 1'b0;
        carryEdge = 1'b0;
        stable = 1'b0;
        pllRun = 1'b0;

        // Three-stage pin sync; only the last two stages, pinSync[1] and pinSync[2], are compared
        next_r.pinSync = {r.pinSync[1:0], enablePin};
        stable = (r.pinSync[2] == r.pinSync[1]);

        // Accept a new level only after it held the whole filter time [RQ7] [RQ18]
        if (!stable || r.pinSync[2] == r.filtLevel) begin
            next_r.filtCnt = '0;
        end else if (r.filtCnt == EPR_FILT_W'(EPR_FILTER_CYCLES - 1)) begin
            next_r.filtCnt = '0;
            next_r.filtLevel = r.pinSync[2];
            rise = r.pinSync[2];
            fall = !r.pinSync[2];
        end else begin
            next_r.filtCnt = r.filtCnt + 1'b1;
        end

        // Carry pulse comes from the same clock domain, edge found directly
        next_r.carryLast = carryPulse;
        carryEdge = carryPulse && !r.carryLast;

        // Enable reset sequencer; a falling pin level aborts the sequence
        next_r.enableReset = 1'b0;
        case (r.state)
            EPR_IDLE: begin
                next_r.carryCnt = 4'h0;
                if (rise) begin
                    next_r.state = EPR_COUNT; // [RQ6]
                end
            end
            EPR_COUNT: begin
                if (!r.filtLevel) begin
                    next_r.state = EPR_IDLE;
                end else if (carryEdge) begin
                    next_r.carryCnt = r.carryCnt + 1'b1; // [RQ9]
                    // Field n means n counts; a count of one fires on the first edge [RQ10] [RQ17]
                    if (r.carryCnt + 4'h1 == r.resetCount) begin
                        next_r.state = EPR_FIRE;
                    end
                end
            end
            EPR_FIRE: begin
                next_r.enableReset = 1'b1; // [RQ9] [RQ13]
                next_r.resetDone = 1'b1;
                next_r.state = EPR_IDLE;
            end
            default: begin
                next_r.state = EPR_IDLE;
            end
        endcase

        // Count register lives across watchdog and enable resets, reloads on clock stop [RQ12]
        if (bus.wr && hit(bus.addr, EPR_ADDR_RESET_COUNT)) begin
            next_r.resetCount = bus.wdata; // [RQ11]
        end
        if (clockStop) begin
            next_r.resetCount = EPR_RESET_COUNT_INIT; // [RQ12] [RQ17]
        end

        // PLL setup registers; the latch clears only after both are rewritten [RQ4]
        if (bus.wr && hit(bus.addr, EPR_ADDR_PLL_MODE)) begin
            next_r.pllMode = bus.wdata;
            next_r.modeWritten = 1'b1;
        end
        if (bus.wr && hit(bus.addr, EPR_ADDR_PLL_REF)) begin
            next_r.pllRef = bus.wdata;
            next_r.refWritten = 1'b1;
        end
        if (bus.wr && hit(bus.addr, EPR_ADDR_PLL_CTRL)) begin
            next_r.swPllOff = bus.wdata[0]; // [RQ3]
        end
        if (next_r.modeWritten && next_r.refWritten) begin
            next_r.pllLatchedOff = 1'b0;
            next_r.modeWritten = 1'b0;
            next_r.refWritten = 1'b0;
        end
        // Any disable condition latches the PLL off; this set wins over a re-arm
        if (!r.filtLevel || r.swPllOff || clockStop) begin
            next_r.pllLatchedOff = 1'b1; // [RQ1] [RQ4]
            next_r.modeWritten = 1'b0;
            next_r.refWritten = 1'b0;
        end
        pllRun = r.filtLevel && !r.swPllOff && !r.pllLatchedOff && !clockStop; // [RQ1] [RQ3]

        // Pin states: PLL pins parked when off, crystal parked in clock stop
        next_r.pins.pllEnable = pllRun;
        next_r.pins.oscPullDown = !pllRun; // [RQ2]
        next_r.pins.errOutEnable = pllRun; // [RQ2]
        next_r.pins.xtalInPullDown = clockStop; // [RQ15]
        next_r.pins.xtalOutHigh = clockStop; // [RQ15]

        // Sticky flags: write one clears, a same-cycle event wins [RQ16]
        if (bus.wr && hit(bus.addr, EPR_ADDR_IRQ_STATUS)) begin
            if (bus.wdata[EPR_BIT_IRQ_FLAG]) begin
                next_r.irqFlag = 1'b0;
            end
            if (bus.wdata[EPR_BIT_RESET_DONE]) begin
                next_r.resetDone = 1'b0;
            end
        end
        if (fall) begin
            next_r.irqFlag = 1'b1; // [RQ5]
        end
        if (r.state == EPR_FIRE) begin
            next_r.resetDone = 1'b1;
        end
        if (bus.wr && hit(bus.addr, EPR_ADDR_IRQ_MASK)) begin
            next_r.irqMask = bus.wdata;
        end

        // Level interrupt, high while an unmasked sticky bit stands
        next_r.irq = |({1'b0, next_r.resetDone, 1'b0, next_r.irqFlag} & next_r.irqMask);

        // Read data appear the cycle after the strobe
        next_r.rdata = 4'h0;
        if (bus.rd) begin
            if (hit(bus.addr, EPR_ADDR_RESET_COUNT)) begin
                next_r.rdata = r.resetCount;
            end else if (hit(bus.addr, EPR_ADDR_IRQ_STATUS)) begin
                next_r.rdata = {r.resetDone, r.resetDone, r.filtLevel, r.irqFlag} & 4'h7;
            end else if (hit(bus.addr, EPR_ADDR_PLL_MODE)) begin
                next_r.rdata = r.pllMode;
            end else if (hit(bus.addr, EPR_ADDR_PLL_REF)) begin
                next_r.rdata = r.pllRef;
            end else if (hit(bus.addr, EPR_ADDR_PLL_CTRL)) begin
                next_r.rdata = {2'b00, r.pllLatchedOff, r.swPllOff};
            end else if (hit(bus.addr, EPR_ADDR_IRQ_MASK)) begin
                next_r.rdata = r.irqMask;
            end else begin
                next_r.rdata = 4'h0;
            end
        end

        // Core reset: any source restarts the core from address zero [RQ13] [RQ14]
        next_r.coreReset = next_r.enableReset || watchdogStackReset || resetPin;
    end

    // Power-on reset loads every field; other resets keep registers
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            r <= '0;
            r.state <= EPR_IDLE;
            r.resetCount <= EPR_RESET_COUNT_INIT; // [RQ12]
            r.pllMode <= EPR_PLL_MODE_INIT;
            r.pllRef <= EPR_PLL_REF_INIT;
            r.irqMask <= EPR_MASK_INIT;
            r.pllLatchedOff <= 1'b1;
            r.pins.oscPullDown <= 1'b1;
            r.coreReset <= 1'b1; // [RQ14]
        end else begin
            r <= next_r;
        end
    end

    assign rdata = r.rdata;
    assign pins = r.pins;
    assign irq = r.irq;
    assign coreReset = r.coreReset;
    assign enableReset = r.enableReset;
endmodule : epr_enable_pin_reset
`default_nettype wire

//--- testbench/epr_props.sv
// Checker for the enable-pin reset control ports
`timescale 1ns/1ps
`default_nettype none
module epr_props (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic enablePin,
    input wire logic carryPulse,
    input wire logic clockStop,
    input wire logic watchdogStackReset,
    input wire logic resetPin,
    input wire epr_pkg::epr_bus_t bus,
    input wire logic [3:0] rdata,
    input wire epr_pkg::epr_pins_t pins,
    input wire logic irq,
    input wire logic coreReset,
    input wire logic enableReset
);
    import epr_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // Pin states follow the PLL enable, raw pin must have been high before a start
    property p_pll_pins; !pins.pllEnable |-> pins.oscPullDown && !pins.errOutEnable; endproperty
    a_pll_pins: assert property (p_pll_pins) else $error("pll pins wrong");
    property p_pll_pin; $rose(pins.pllEnable) |-> $past(enablePin, 8); endproperty
    a_pll_pin: assert property (p_pll_pin) else $error("pll on without pin");
    property p_xtal; clockStop |=> pins.xtalInPullDown && pins.xtalOutHigh; endproperty
    a_xtal: assert property (p_xtal) else $error("crystal pins wrong");
    // Every reset source reaches the core within one cycle
    property p_other_rst; resetPin || watchdogStackReset |=> coreReset; endproperty
    a_other_rst: assert property (p_other_rst) else $error("core reset missed");
    property p_en_core; enableReset |-> coreReset; endproperty
    a_en_core: assert property (p_en_core) else $error("enable reset not on core");
    property p_en_pulse; enableReset |=> !enableReset; endproperty
    a_en_pulse: assert property (p_en_pulse) else $error("enable reset too long");
    property p_en_pin; enableReset |-> $past(enablePin, 1); endproperty
    a_en_pin: assert property (p_en_pin) else $error("enable reset with pin low");
    // Read data only stand in the cycle after a read strobe
    property p_rd_idle; !$past(bus.rd) |-> rdata == 4'h0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
    c_fired: cover property (enableReset);
    c_irq: cover property (irq);
    c_pll: cover property (pins.pllEnable);
endmodule : epr_props
`default_nettype wire

//--- testbench/epr_pin_model.sv
// Model of the external controller that drives the enable pin
`timescale 1ns/1ps
`default_nettype none
module epr_pin_model (
    input wire logic sys_clk,
    output var logic enablePin
);
    initial enablePin = 1'b0;
    // Callers hold levels past the filter time; shorter holds are deliberate glitches
    task automatic drive(input logic level, input int holdCycles);
        @(posedge sys_clk);
        enablePin <= level;
        repeat (holdCycles) @(posedge sys_clk);
    endtask : drive
endmodule : epr_pin_model
`default_nettype wire

//--- testbench/enable_pin_reset_control_test.sv
// Self-checking bench for the enable-pin reset control block
`timescale 1ns/1ps
`default_nettype none
module enable_pin_reset_control_test;
    import epr_pkg::*;
    localparam int FILT = EPR_FILTER_CYCLES + 16; // Filter plus synchroniser margin
    logic sys_clk, sys_rst, carryPulse, clockStop, watchdogStackReset, resetPin, enablePin;
    epr_bus_t bus;
    logic [3:0] rdata;
    epr_pins_t pins;
    logic irq, coreReset, enableReset;
    int n_errors = 0, comparisons = 0, nFired = 0;
    epr_pin_model u_pin (.sys_clk(sys_clk), .enablePin(enablePin));
    epr_enable_pin_reset u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .enablePin(enablePin),
        .carryPulse(carryPulse), .clockStop(clockStop), .watchdogStackReset(watchdogStackReset),
        .resetPin(resetPin), .bus(bus), .rdata(rdata), .pins(pins), .irq(irq),
        .coreReset(coreReset), .enableReset(enableReset));
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    // Totals of enable-pin reset pulses, read by the scenarios
    always @(posedge sys_clk) if (enableReset === 1'b1) nFired++;
    task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic regWrite(input logic [7:0] a, input logic [3:0] d);
        @(posedge sys_clk);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge sys_clk);
        bus.wr <= 1'b0;
    endtask : regWrite
    // Read data stand only in the cycle after the strobe
    task automatic regRead(input logic [7:0] a, output logic [3:0] d);
        @(posedge sys_clk);
        bus <= '{a, 4'h0, 1'b0, 1'b1};
        @(posedge sys_clk);
        bus.rd <= 1'b0;
        #1 d = rdata;
    endtask : regRead
    task automatic regCheck(input string what, input logic [7:0] a, input logic [3:0] exp);
        logic [3:0] d;
        regRead(a, d);
        chk(what, exp, d);
    endtask : regCheck
    // Lets registered outputs settle before they are sampled
    task automatic settle;
        repeat (3) @(posedge sys_clk);
        #1;
    endtask : settle
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge sys_clk);
            carryPulse <= 1'b1;
            repeat (3) @(posedge sys_clk);
            carryPulse <= 1'b0;
            repeat (3) @(posedge sys_clk);
        end
    endtask : pulse
    task automatic t_regs;
        regCheck("count init", EPR_ADDR_RESET_COUNT, EPR_RESET_COUNT_INIT);
        regWrite(EPR_ADDR_RESET_COUNT, 4'hF);
        regCheck("count rw", EPR_ADDR_RESET_COUNT, 4'hF);
        regCheck("unmapped", 8'hFF, 4'h0);
        regWrite(EPR_ADDR_RESET_COUNT, 4'h5);
        @(posedge sys_clk) watchdogStackReset <= 1'b1;
        @(posedge sys_clk) watchdogStackReset <= 1'b0;
        regCheck("count kept", EPR_ADDR_RESET_COUNT, 4'h5);
        @(posedge sys_clk) clockStop <= 1'b1;
        @(posedge sys_clk) clockStop <= 1'b0;
        regCheck("count on stop", EPR_ADDR_RESET_COUNT, 4'h1);
    endtask : t_regs
    task automatic t_rise;
        logic [3:0] d;
        int n0;
        regWrite(EPR_ADDR_RESET_COUNT, 4'h3);
        u_pin.drive(1'b1, FILT);
        regRead(EPR_ADDR_IRQ_STATUS, d);
        chk("level high", 4'h2, d & 4'h3);
        n0 = nFired;
        pulse(2);
        chk("early reset", 4'h0, 4'(nFired - n0));
        pulse(1);
        chk("reset fired", 4'h1, 4'(nFired - n0));
        settle();
        chk("pll latched", 4'h0, {3'h0, pins.pllEnable});
        regWrite(EPR_ADDR_PLL_MODE, 4'h1);
        regWrite(EPR_ADDR_PLL_REF, 4'h1);
        settle();
        chk("pll armed", 4'h1, {3'h0, pins.pllEnable});
        regWrite(EPR_ADDR_PLL_CTRL, 4'h1);
        settle();
        chk("pll sw off", 4'h0, {3'h0, pins.pllEnable});
        regWrite(EPR_ADDR_PLL_CTRL, 4'h0);
        settle();
        chk("pll stays off", 4'h0, {3'h0, pins.pllEnable});
    endtask : t_rise
    task automatic t_glitch;
        logic [3:0] d;
        u_pin.drive(1'b0, 2000);
        u_pin.drive(1'b1, 20);
        regRead(EPR_ADDR_IRQ_STATUS, d);
        chk("glitch", 4'h2, d & 4'h3);
    endtask : t_glitch
    task automatic t_fall;
        logic [3:0] d;
        logic i1;
        regWrite(EPR_ADDR_PLL_MODE, 4'h2);
        regWrite(EPR_ADDR_PLL_REF, 4'h2);
        u_pin.drive(1'b0, FILT);
        chk("pll pin low", 4'h0, {3'h0, pins.pllEnable});
        regRead(EPR_ADDR_IRQ_STATUS, d);
        chk("fall flag", 4'h1, d & 4'h3);
        regWrite(EPR_ADDR_IRQ_MASK, 4'h1);
        settle();
        i1 = irq;
        regWrite(EPR_ADDR_IRQ_MASK, 4'h0);
        settle();
        chk("irq mask", 4'h1, {3'h0, i1 ^ irq});
        regWrite(EPR_ADDR_IRQ_STATUS, 4'h1);
        regRead(EPR_ADDR_IRQ_STATUS, d);
        chk("flag clear", 4'h0, d & 4'h1);
        @(posedge sys_clk) resetPin <= 1'b1;
        @(posedge sys_clk) resetPin <= 1'b0;
        settle();
    endtask : t_fall
    task automatic final_report;
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report
    initial begin
        sys_rst = 1'b1;
        bus = '0;
        carryPulse = 1'b0;
        clockStop = 1'b0;
        watchdogStackReset = 1'b0;
        resetPin = 1'b0;
        repeat (12) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_regs();
        t_rise();
        t_glitch();
        t_fall();
        final_report();
    end
    // Four filter spans plus margin; a hang ends the run as a failure
    initial begin
        repeat (90000) @(posedge sys_clk);
        n_errors++;
        final_report();
    end
endmodule : enable_pin_reset_control_test
bind epr_enable_pin_reset epr_props u_props (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .enablePin(enablePin), .carryPulse(carryPulse), .clockStop(clockStop),
    .watchdogStackReset(watchdogStackReset), .resetPin(resetPin), .bus(bus), .rdata(rdata),
    .pins(pins), .irq(irq), .coreReset(coreReset), .enableReset(enableReset));
`default_nettype wire
